// >>> shared/gcs_pkg.sv
// package for the gauge control subcommand unit
package gcs_pkg;
  localparam logic [7:0] GCS_ADDR_CTRL_LO = 8'h00;
  localparam logic [7:0] GCS_ADDR_CTRL_HI = 8'h01;
  localparam logic [15:0] SC_STATUS = 16'h0000;
  localparam logic [15:0] SC_PART_TYPE = 16'h0001;
  localparam logic [15:0] SC_FW_REV = 16'h0002;
  localparam logic [15:0] SC_LAST_SUB = 16'h0007;
  localparam logic [15:0] SC_READ_CHEMISTRY_IDENTIFIER = 16'h0008;
  localparam logic [15:0] SC_LAST_SUB_MAX = 16'h0009;
  localparam logic [15:0] SC_OCV_REQ = 16'h000C;
  localparam logic [15:0] SC_PACK_IN = 16'h000D;
  localparam logic [15:0] SC_PACK_OUT = 16'h000E;
  localparam logic [15:0] SC_HIB_SET = 16'h0011;
  localparam logic [15:0] SC_HIB_CLR = 16'h0012;
  localparam logic [15:0] SC_DOZE_ON = 16'h0013;
  localparam logic [15:0] SC_DOZE_OFF = 16'h0014;
  localparam logic [15:0] SC_RESTORE = 16'h0015;
  localparam logic [15:0] SC_LOG_ON = 16'h0018;
  localparam logic [15:0] SC_LOG_OFF = 16'h0019;
  localparam logic [15:0] SC_STORE_REV = 16'h001F;
  localparam logic [15:0] SC_LOCK = 16'h0020;
  localparam logic [15:0] SC_ALGO_ON = 16'h0021;
  localparam logic [15:0] SC_ALGO_OFF = 16'h0023;
  localparam logic [15:0] SC_FULL_RESET = 16'h0041;
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1000;
  localparam int PULSE_MS = 165;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_MS;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  typedef struct packed {
    logic log_active_flag;
    logic full_access_locked_flag;
    logic locked;
    logic checksum_valid_flag;
    logic counter_cal_active;
    logic board_cal_active;
    logic open_voltage_done;
    logic open_voltage_failed;
    logic init_done_flag;
    logic hibernate_request;
    logic light_doze_enable;
    logic in_sleep;
    logic constant_power_model;
    logic resistance_update_off;
    logic voltage_good_flag;
    logic capacity_update_enable;
  } gcs_status_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } gcs_wr_t;
endpackage : gcs_pkg

// >>> hdl/gcs_unit.sv
// gauge control subcommand unit
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - host writes control command pair then two-byte subcommand selecting function
// R2 - low byte at lower address, high byte upper; act when both arrived
// R3 - subcommand 0x0000 puts status word on control addresses
// R4 - status high byte: log, full lock, lock, checksum, cc cal, board cal, ocv
// R5 - status low byte: init, hibernate, doze, sleep, power model, ra off, vok, qen
// R6 - init, ocv done and ocv failed bits set only with pack present
// R7 - 0x0001, 0x0002, 0x0008 return part type, firmware and chemistry codes
// R8 - 0x0007 returns previous subcommand, or 0x0007 if previous above 0x0009
// R9 - host sends voltage request only after init done is set
// R10 - voltage measurement starts at next 1 s tick, pin pulses 165 ms
// R11 - host cuts load below C/20 within 8 ms and holds through window
// R12 - voltage request while charge inhibit set sets measurement failed
// R13 - 0x000d sets pack present when insertion detect disabled
// R14 - 0x000e clears pack present when insertion detect disabled
// R15 - with insertion detect enabled, pack present follows thermistor detection
// R16 - 0x0011 sets hibernate request allowing hibernate after sleep
// R17 - hibernate request clears automatically when leaving hibernate
// R18 - 0x0012 clears hibernate request and forces exit from hibernate
// R19 - 0x0013 sets doze enable, 0x0014 clears it
// R20 - 0x0018 starts logging, 0x0019 stops it, both allowed when locked
// R21 - 0x001F returns storage revision, 0x0020 locks the part
// R22 - restore, lock, algo on, algo off and full reset refused when locked
// R23 - 0x0023 disables gauging algorithm, 0x0015 restores learned defaults
// R24 - undefined subcommand codes are ignored with status unchanged
module gcs_unit
  import gcs_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int PULSE_CYC = PULSE_CYCLES,
  parameter logic [15:0] PART_TYPE = 16'h1234, // arbitrary value
  parameter logic [15:0] FW_REV = 16'h0101, // arbitrary value
  parameter logic [15:0] READ_CHEMISTRY_IDENTIFIER = 16'h0100,
  parameter logic [15:0] STORE_REV = 16'h0000
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // register port from serial engine
  input wire gcs_wr_t i_wr,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // gauge state inputs
  input wire logic i_insertion_detect_enable,
  input wire logic i_thermistor_pack_sense,
  input wire logic i_charge_inhibit_flag,
  input wire logic i_init_done,
  input wire logic i_in_sleep,
  input wire logic i_in_hibernate,
  input wire logic i_hibernate_exit,
  input wire logic i_ocv_result_bad,
  input wire logic i_checksum_valid,
  input wire logic i_counter_cal_active,
  input wire logic i_board_cal_active,
  input wire logic i_constant_power_model,
  input wire logic i_resistance_update_off,
  input wire logic i_voltage_good,
  // control outputs
  output logic o_soc_int,
  output logic o_pack_present_flag,
  output logic o_force_wake,
  output logic o_restore_defaults,
  output logic o_full_reset,
  output logic o_algo_enable,
  output logic [15:0] o_status
);
  gcs_status_t status_reg;
  logic [15:0] ctrl_reg;
  logic [7:0] lo_byte_reg;
  logic lo_seen_reg;
  logic [15:0] prev_sub_reg;
  logic cmd_fire;
  logic [15:0] cmd_code;
  logic locked_refuse;
  logic [2:0] sense_sync;
  logic sense_stable;
  logic ocv_pending_reg;
  logic [31:0] tick_cnt_reg;
  logic [31:0] pulse_cnt_reg;
  logic tick;
  logic pack_ok;

  assign cmd_code = {i_wr.data, lo_byte_reg};
  // [R1] [R2] act once the high byte completes the pair
  assign cmd_fire = i_wr.valid && i_wr.addr == GCS_ADDR_CTRL_HI && lo_seen_reg;
  // [R22]
  assign locked_refuse = status_reg.locked && (cmd_code == SC_RESTORE || cmd_code == SC_LOCK
      || cmd_code == SC_ALGO_ON || cmd_code == SC_ALGO_OFF || cmd_code == SC_FULL_RESET);
  assign pack_ok = o_pack_present_flag;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lo_byte_reg <= 8'h00;
      lo_seen_reg <= 1'b0;
    end else if (i_wr.valid && i_wr.addr == GCS_ADDR_CTRL_LO) begin
      lo_byte_reg <= i_wr.data; // [R2]
      lo_seen_reg <= 1'b1;
    end else if (cmd_fire) begin
      lo_seen_reg <= 1'b0;
    end
  end

  // thermistor sense, three stage, change counts when last two agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sense_sync <= 3'h0;
      sense_stable <= 1'b0;
    end else begin
      sense_sync <= {sense_sync[1:0], i_thermistor_pack_sense};
      if (sense_sync[2] == sense_sync[1]) begin
        sense_stable <= sense_sync[2];
      end
    end
  end

  // pack present flag
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pack_present_flag <= 1'b0;
    end else if (i_insertion_detect_enable) begin
      o_pack_present_flag <= sense_stable; // [R15]
    end else if (cmd_fire && cmd_code == SC_PACK_IN) begin
      o_pack_present_flag <= 1'b1; // [R13]
    end else if (cmd_fire && cmd_code == SC_PACK_OUT) begin
      o_pack_present_flag <= 1'b0; // [R14]
    end
  end

  // 1 s tick divider
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick_cnt_reg == 32'(TICK_CYC - 1)) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = tick_cnt_reg == 32'(TICK_CYC - 1);

  // voltage measurement window on the interrupt pin
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ocv_pending_reg <= 1'b0;
      pulse_cnt_reg <= 32'h0;
      o_soc_int <= 1'b0;
    end else begin
      if (cmd_fire && cmd_code == SC_OCV_REQ && !i_charge_inhibit_flag && pack_ok) begin
        ocv_pending_reg <= 1'b1;
      end else if (tick && ocv_pending_reg) begin
        ocv_pending_reg <= 1'b0;
      end
      if (tick && ocv_pending_reg) begin
        o_soc_int <= 1'b1; // [R10]
        pulse_cnt_reg <= 32'(PULSE_CYC - 1);
      end else if (pulse_cnt_reg != 32'h0) begin
        pulse_cnt_reg <= pulse_cnt_reg - 32'h1;
      end else begin
        o_soc_int <= 1'b0;
      end
    end
  end

  // status word and command effects
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg <= gcs_status_t'(STATUS_RESET);
      o_algo_enable <= 1'b0;
    end else begin
      status_reg.checksum_valid_flag <= i_checksum_valid;
      status_reg.counter_cal_active <= i_counter_cal_active;
      status_reg.board_cal_active <= i_board_cal_active;
      status_reg.in_sleep <= i_in_sleep;
      status_reg.constant_power_model <= i_constant_power_model;
      status_reg.resistance_update_off <= i_resistance_update_off;
      status_reg.voltage_good_flag <= i_voltage_good;
      status_reg.full_access_locked_flag <= status_reg.locked;
      status_reg.init_done_flag <= i_init_done && pack_ok; // [R6]
      if (i_hibernate_exit) begin
        status_reg.hibernate_request <= 1'b0; // [R17]
      end
      if (cmd_fire && !locked_refuse) begin
        unique case (cmd_code)
          SC_OCV_REQ: begin
            status_reg.open_voltage_done <= 1'b0;
            status_reg.open_voltage_failed <= i_charge_inhibit_flag && pack_ok; // [R12]
          end
          SC_HIB_SET: status_reg.hibernate_request <= 1'b1; // [R16]
          SC_HIB_CLR: status_reg.hibernate_request <= 1'b0; // [R18]
          SC_DOZE_ON: status_reg.light_doze_enable <= 1'b1; // [R19]
          SC_DOZE_OFF: status_reg.light_doze_enable <= 1'b0; // [R19]
          SC_LOG_ON: status_reg.log_active_flag <= 1'b1; // [R20]
          SC_LOG_OFF: status_reg.log_active_flag <= 1'b0; // [R20]
          SC_LOCK: status_reg.locked <= 1'b1; // [R21]
          SC_ALGO_ON: begin
            o_algo_enable <= 1'b1;
            status_reg.capacity_update_enable <= 1'b1;
          end
          SC_ALGO_OFF: begin
            o_algo_enable <= 1'b0; // [R23]
            status_reg.capacity_update_enable <= 1'b0;
          end
          default: begin
          end // [R24]
        endcase
      end
      // a window that ends as a new request arrives still reports its result
      if (pulse_cnt_reg == 32'h1 && pack_ok) begin
        status_reg.open_voltage_done <= 1'b1; // [R6]
        if (i_ocv_result_bad) begin
          status_reg.open_voltage_failed <= 1'b1;
        end
      end
    end
  end

  // one-cycle command strobes
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_force_wake <= 1'b0;
      o_restore_defaults <= 1'b0;
      o_full_reset <= 1'b0;
    end else begin
      o_force_wake <= cmd_fire && cmd_code == SC_HIB_CLR && i_in_hibernate; // [R18]
      o_restore_defaults <= cmd_fire && cmd_code == SC_RESTORE && !locked_refuse; // [R23]
      o_full_reset <= cmd_fire && cmd_code == SC_FULL_RESET && !locked_refuse; // [R22]
    end
  end

  // control answer word and previous subcommand
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_reg <= 16'h0000;
      prev_sub_reg <= 16'h0000;
    end else if (cmd_fire) begin
      prev_sub_reg <= cmd_code;
      unique case (cmd_code)
        SC_STATUS: ctrl_reg <= status_reg; // [R3] [R4] [R5]
        SC_PART_TYPE: ctrl_reg <= PART_TYPE; // [R7]
        SC_FW_REV: ctrl_reg <= FW_REV; // [R7]
        SC_READ_CHEMISTRY_IDENTIFIER: ctrl_reg <= READ_CHEMISTRY_IDENTIFIER; // [R7]
        SC_LAST_SUB: ctrl_reg <= (prev_sub_reg > SC_LAST_SUB_MAX)
            ? SC_LAST_SUB : prev_sub_reg; // [R8]
        SC_STORE_REV: ctrl_reg <= STORE_REV; // [R21]
        default: ctrl_reg <= ctrl_reg;
      endcase
    end else if (i_wr.valid && i_wr.addr == GCS_ADDR_CTRL_LO) begin
      ctrl_reg <= ctrl_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_addr == GCS_ADDR_CTRL_LO) begin
      o_rd_data <= ctrl_reg[7:0];
    end else if (i_rd_addr == GCS_ADDR_CTRL_HI) begin
      o_rd_data <= ctrl_reg[15:8];
    end else begin
      o_rd_data <= 8'h00;
    end
  end
  assign o_status = status_reg;

  a_lock_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(status_reg.locked) |=> status_reg.locked [*4]) else $error("lock dropped"); // [R21]
  a_doze_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R19]
    cmd_fire && cmd_code == SC_DOZE_ON |=> status_reg.light_doze_enable)
    else $error("doze not set");
  a_doze_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R19]
    cmd_fire && cmd_code == SC_DOZE_OFF |=> !status_reg.light_doze_enable)
    else $error("doze not cleared");
  a_log_on: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R20]
    cmd_fire && cmd_code == SC_LOG_ON |=> status_reg.log_active_flag)
    else $error("log not started");
  a_lock_refuse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R22]
    cmd_fire && status_reg.locked && cmd_code == SC_FULL_RESET |=> !o_full_reset)
    else $error("reset accepted while locked");
  a_init_pack: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R6]
    status_reg.init_done_flag |-> $past(pack_ok)) else $error("init without pack");
  a_pack_in: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R13]
    cmd_fire && cmd_code == SC_PACK_IN && !i_insertion_detect_enable |=> o_pack_present_flag)
    else $error("pack not forced");
  a_pulse_start: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R10]
    tick && ocv_pending_reg |=> o_soc_int && pulse_cnt_reg == 32'(PULSE_CYC - 1))
    else $error("pulse not started");
  a_ocv_fail: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
    cmd_fire && cmd_code == SC_OCV_REQ && i_charge_inhibit_flag && pack_ok
    |=> status_reg.open_voltage_failed) else $error("ocv fail not set");
  // effects one cycle after the high byte fires, a hibernate exit or insertion detect enable
  a_ocv_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R10]
    cmd_fire && cmd_code == SC_OCV_REQ && !i_charge_inhibit_flag && pack_ok
    |=> ocv_pending_reg) else $error("ocv request not pending");
  a_hib_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R16]
    cmd_fire && cmd_code == SC_HIB_SET |=> status_reg.hibernate_request)
    else $error("hibernate request not set");
  a_hib_exit: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R17]
    i_hibernate_exit && !(cmd_fire && cmd_code == SC_HIB_SET)
    |=> !status_reg.hibernate_request) else $error("hibernate request kept on exit");
  a_hib_clr: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R18]
    cmd_fire && cmd_code == SC_HIB_CLR |=> !status_reg.hibernate_request)
    else $error("hibernate request not cleared");
  a_wake_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R18]
    cmd_fire && cmd_code == SC_HIB_CLR && i_in_hibernate |=> o_force_wake)
    else $error("no forced wake");
  a_log_off: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R20]
    cmd_fire && cmd_code == SC_LOG_OFF |=> !status_reg.log_active_flag)
    else $error("log not stopped");
  a_lock_set: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R21]
    cmd_fire && cmd_code == SC_LOCK |=> status_reg.locked)
    else $error("lock not taken");
  a_algo_refuse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R22]
    cmd_fire && status_reg.locked && (cmd_code == SC_ALGO_ON || cmd_code == SC_ALGO_OFF)
    |=> $stable(o_algo_enable)) else $error("algo change accepted while locked");
  a_restore_refuse: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R22]
    cmd_fire && status_reg.locked && cmd_code == SC_RESTORE |=> !o_restore_defaults)
    else $error("restore accepted while locked");
  a_restore_go: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R23]
    cmd_fire && !status_reg.locked && cmd_code == SC_RESTORE |=> o_restore_defaults)
    else $error("restore not issued");
  a_pack_out: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
    cmd_fire && cmd_code == SC_PACK_OUT && !i_insertion_detect_enable
    |=> !o_pack_present_flag) else $error("pack not cleared");
  a_pack_sense: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R15]
    i_insertion_detect_enable |=> o_pack_present_flag == $past(sense_stable))
    else $error("pack flag not following sense");
  a_status_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R3]
    cmd_fire && cmd_code == SC_STATUS |=> ctrl_reg == $past(status_reg))
    else $error("status word not answered");
  a_part_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
    cmd_fire && cmd_code == SC_PART_TYPE |=> ctrl_reg == PART_TYPE)
    else $error("part type not answered");
  a_last_cap: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
    cmd_fire && cmd_code == SC_LAST_SUB |=> ctrl_reg <= SC_LAST_SUB_MAX)
    else $error("last code above limit");
  c_ocv: cover property (@(posedge i_clk) $rose(o_soc_int));
  c_lock: cover property (@(posedge i_clk) $rose(status_reg.locked));
  c_status_read: cover property (@(posedge i_clk) cmd_fire && cmd_code == SC_STATUS);
  c_wake: cover property (@(posedge i_clk) o_force_wake);
  c_pack_sensed: cover property (@(posedge i_clk) i_insertion_detect_enable && $rose(pack_ok));
endmodule : gcs_unit
`default_nettype wire

// >>> dv/gcs_host_model.sv
// host model that writes subcommands and reads the control word
`timescale 1ns/1ps
`default_nettype none
module gcs_host_model
  import gcs_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register port toward the unit
  output gcs_wr_t o_wr,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  initial begin
    o_wr = '{valid: 1'b0, addr: 8'h00, data: 8'hFF};
    o_rd_addr = 8'h02;
  end
  // low byte at the lower address, then the high byte fires the code
  task automatic send(input logic [15:0] code);
    @(negedge i_clk);
    o_wr <= '{valid: 1'b1, addr: GCS_ADDR_CTRL_LO, data: code[7:0]};
    @(negedge i_clk);
    o_wr <= '{valid: 1'b1, addr: GCS_ADDR_CTRL_HI, data: code[15:8]};
    @(negedge i_clk);
    // idle data shows the inverse so a stale byte is never mistaken
    o_wr <= '{valid: 1'b0, addr: 8'h00, data: ~code[15:8]};
    repeat (2) @(negedge i_clk);
  endtask : send
  task automatic read(output logic [15:0] word);
    o_rd_addr <= GCS_ADDR_CTRL_LO;
    @(negedge i_clk);
    word[7:0] = i_rd_data;
    o_rd_addr <= GCS_ADDR_CTRL_HI;
    @(negedge i_clk);
    word[15:8] = i_rd_data;
    o_rd_addr <= 8'h02;
  endtask : read
endmodule : gcs_host_model
`default_nettype wire

// >>> dv/tb.sv
// testbench for the gauge control subcommand unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gcs_pkg::*;
  localparam int TICK = 100;
  localparam int PULSE = 20;
  localparam logic [15:0] PART = 16'h1234; // arbitrary value
  localparam logic [15:0] FWR = 16'h0101; // arbitrary value
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  gcs_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic insertion_detect_enable = 0, therm = 0, inh = 0, init = 0, slp = 0, hib = 0, hexit = 0;
  logic [5:0] mir = '0;
  logic soc, pack, wake, rest, frst, algo, soc_d = 0;
  gcs_status_t st;
  gcs_status_t w;
  int failures = 0, checked = 0, n_wake = 0, n_rest = 0, n_frst = 0, n_soc = 0;
  always #4 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    soc_d <= soc;
    n_soc <= n_soc + int'(soc & ~soc_d);
    n_wake <= n_wake + int'(wake);
    n_rest <= n_rest + int'(rest);
    n_frst <= n_frst + int'(frst);
  end
  gcs_host_model u_host (.i_clk(i_clk), .o_wr(wr), .o_rd_addr(rd_addr), .i_rd_data(rd_data));
  gcs_unit #(.TICK_CYC(TICK), .PULSE_CYC(PULSE), .PART_TYPE(PART), .FW_REV(FWR)) u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(wr), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .i_insertion_detect_enable(insertion_detect_enable), .i_thermistor_pack_sense(therm),
    .i_charge_inhibit_flag(inh), .i_init_done(init), .i_in_sleep(slp), .i_in_hibernate(hib),
    .i_hibernate_exit(hexit), .i_ocv_result_bad(1'b0), .i_checksum_valid(mir[5]),
    .i_counter_cal_active(mir[4]), .i_board_cal_active(mir[3]),
    .i_constant_power_model(mir[2]), .i_resistance_update_off(mir[1]),
    .i_voltage_good(mir[0]), .o_soc_int(soc), .o_pack_present_flag(pack),
    .o_force_wake(wake), .o_restore_defaults(rest), .o_full_reset(frst),
    .o_algo_enable(algo), .o_status(st));
  task automatic cmp_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      failures++;
    end
  endtask : cmp_word
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      failures++;
    end
  endtask : cmp_bit
  task automatic finish_test();
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task automatic t_ident();
    logic [15:0] codes [4] = '{SC_PART_TYPE, SC_FW_REV, SC_READ_CHEMISTRY_IDENTIFIER, SC_STORE_REV};
    logic [15:0] exps [4] = '{PART, FWR, 16'h0100, 16'h0000};
    logic [15:0] v;
    cmp_word("status at reset", 16'h0000, st);
    for (int i = 0; i < 4; i++) begin
      u_host.send(codes[i]);
      u_host.read(v);
      cmp_word("ident word", exps[i], v);
    end
  endtask : t_ident
  task automatic t_last();
    logic [15:0] prev [3] = '{SC_READ_CHEMISTRY_IDENTIFIER, 16'h0009, SC_DOZE_ON};
    logic [15:0] exps [3] = '{SC_READ_CHEMISTRY_IDENTIFIER, 16'h0009, SC_LAST_SUB};
    logic [15:0] v;
    for (int i = 0; i < 3; i++) begin
      u_host.send(prev[i]);
      u_host.send(SC_LAST_SUB);
      u_host.read(v);
      cmp_word("last code", exps[i], v);
    end
  endtask : t_last
  task automatic t_status();
    mir = 6'h3F;
    slp = 1;
    u_host.send(SC_LOG_ON);
    u_host.send(SC_HIB_SET);
    u_host.send(SC_STATUS);
    u_host.read(w);
    cmp_word("status word", 16'h9C7E, w);
    cmp_word("status port", 16'h9C7E, st);
    mir = '0;
    slp = 0;
    u_host.send(SC_DOZE_OFF);
    cmp_bit("doze off", 1'b0, st.light_doze_enable);
    u_host.send(SC_LOG_OFF);
    cmp_bit("log off", 1'b0, st.log_active_flag);
  endtask : t_status
  task automatic t_pack();
    init = 1;
    u_host.send(SC_STORE_REV);
    cmp_bit("init without pack", 1'b0, st.init_done_flag);
    u_host.send(SC_PACK_IN);
    cmp_bit("pack in", 1'b1, pack);
    cmp_bit("init with pack", 1'b1, st.init_done_flag);
    u_host.send(SC_PACK_OUT);
    cmp_bit("pack out", 1'b0, pack);
    insertion_detect_enable = 1;
    therm = 1;
    repeat (6) @(negedge i_clk);
    cmp_bit("sensed pack", 1'b1, pack);
    insertion_detect_enable = 0;
  endtask : t_pack
  task automatic t_ocv();
    int n = 0;
    int k = 0;
    u_host.send(SC_OCV_REQ); // init done already set
    while (soc !== 1'b1 && k < TICK + 10) begin
      @(negedge i_clk);
      k++;
    end
    if (k >= TICK + 10) begin
      $display("CHECK FAILED ocv pulse expected 1 seen 0");
      failures++;
      finish_test();
    end
    // count the cycles the pin stays high through the window
    while (soc === 1'b1 && n < PULSE + 5) begin
      @(negedge i_clk);
      n++;
    end
    cmp_word("pulse cycles", 16'(PULSE), 16'(n));
    repeat (2) @(negedge i_clk);
    cmp_bit("ocv done", 1'b1, st.open_voltage_done);
    n = n_soc;
    inh = 1;
    u_host.send(SC_OCV_REQ);
    cmp_bit("ocv failed", 1'b1, st.open_voltage_failed);
    repeat (TICK + PULSE + 10) @(negedge i_clk);
    cmp_word("no pulse", 16'(n), 16'(n_soc));
    inh = 0;
  endtask : t_ocv
  task automatic t_hib();
    int n;
    u_host.send(SC_HIB_CLR);
    cmp_bit("hib clr idle", 1'b0, st.hibernate_request);
    u_host.send(SC_HIB_SET);
    cmp_bit("hib set", 1'b1, st.hibernate_request);
    hexit = 1;
    @(negedge i_clk);
    hexit = 0;
    repeat (2) @(negedge i_clk);
    cmp_bit("hib exit", 1'b0, st.hibernate_request);
    u_host.send(SC_HIB_SET);
    hib = 1;
    n = n_wake;
    u_host.send(SC_HIB_CLR);
    cmp_bit("hib clr", 1'b0, st.hibernate_request);
    cmp_word("wake pulses", 16'(n + 1), 16'(n_wake));
    hib = 0;
  endtask : t_hib
  task automatic t_lock();
    int r;
    int f;
    r = n_rest;
    u_host.send(SC_RESTORE);
    cmp_word("restore", 16'(r + 1), 16'(n_rest));
    u_host.send(SC_ALGO_ON);
    cmp_bit("algo on", 1'b1, algo);
    u_host.send(SC_ALGO_OFF);
    cmp_bit("algo off", 1'b0, algo);
    u_host.send(SC_ALGO_ON);
    u_host.send(SC_LOCK);
    cmp_bit("locked", 1'b1, st.locked);
    f = n_frst;
    u_host.send(SC_RESTORE);
    u_host.send(SC_FULL_RESET);
    u_host.send(SC_ALGO_OFF);
    cmp_word("refused restore", 16'(r + 1), 16'(n_rest));
    cmp_word("refused reset", 16'(f), 16'(n_frst));
    cmp_bit("refused algo off", 1'b1, algo);
    u_host.send(SC_LOG_ON);
    cmp_bit("log when locked", 1'b1, st.log_active_flag);
    w = st;
    u_host.send(16'h0030);
    cmp_word("unknown code", w, st);
  endtask : t_lock
  initial begin
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_sys_rst = 0;
    t_ident();
    t_last();
    t_status();
    t_pack();
    t_ocv();
    t_hib();
    t_lock();
    finish_test();
  end
endmodule : tb
`default_nettype wire
